// File: verilog/udo_pkg.sv
// package: constants shared by both ends of the ultra dma data-out burst
package udo_pkg;
  localparam int DATA_W  = 16;
  localparam int CNT_W   = 8;
  // timing counts for a single mode, in cycles of the host clock
  localparam logic [CNT_W-1:0] T_ACK  = 8'h03;
  localparam logic [CNT_W-1:0] T_ENV  = 8'h02;
  localparam logic [CNT_W-1:0] T_UI   = 8'h01;
  localparam logic [CNT_W-1:0] T_DVS  = 8'h02;
  localparam logic [CNT_W-1:0] T_DVH  = 8'h01;
  localparam logic [CNT_W-1:0] T_CYC  = 8'h06;
  localparam logic [CNT_W-1:0] T_MLI  = 8'h02;
  // device counts, in link clock cycles
  localparam logic [CNT_W-1:0] T_RP   = 8'h04;
  localparam logic [CNT_W-1:0] T_ZIORDY = 8'h01;
  localparam logic [2:0]       EXTRA_LOW  = 3'h2; // modes 0-2
  localparam logic [2:0]       EXTRA_HIGH = 3'h3; // modes 3-4
endpackage

// File: verilog/udo_if.sv
// interface: link wires between host and device ends
`timescale 1ns/1ns
interface udo_if;
  logic        dmarq;
  logic        dmack;     // active high here, the host drives it
  logic        stop;
  logic        hstrobe;
  logic [15:0] dd_out;
  logic        dd_oe;
  logic        ddmardy;   // asserted = ready
  logic        ddmardy_oe;
  modport dev (input dmack, stop, hstrobe, dd_out, dd_oe, output dmarq, ddmardy, ddmardy_oe);
  modport host (output dmack, stop, hstrobe, dd_out, dd_oe, input dmarq, ddmardy, ddmardy_oe);
endinterface

// File: verilog/udo_device.sv
// device end: accepts host words on both strobe edges, pauses, terminates, checks crc
`timescale 1ns/1ns
module udo_device
  import udo_pkg::*;
(
  input  wire logic              link_clk,
  input  wire logic              reset,
  udo_if.dev                     lnk,
  input  wire logic              start,       // request a burst
  input  wire logic              pause,       // hold the host off
  input  wire logic              finish,      // end the burst
  input  wire logic              high_mode,   // modes 3 or 4
  input  wire logic              cmd_clear,   // new command, clears crc error
  input  wire logic [DATA_W-1:0] crc_own,
  output logic [DATA_W-1:0]      word,
  output logic                   word_valid,
  output logic [2:0]             extra_cnt,   // words seen since ready dropped
  output logic                   busy,
  output logic                   crc_err,
  output logic [DATA_W-1:0]      crc_got
);
  // ---------------------------------------------------------------
  // notes
  // ---------------------------------------------------------------
  // every link input passes two flip-flops before any decision reads it
  // the data lines pass the same two stages, so a word lines up with
  // the strobe sample that first shows its edge
  // a strobe edge is seen in the cycle that the second stage first shows it, by comparing
  // that stage with its own delayed copy
  // the host needs a few link cycles to see ready drop, so words that
  // arrive after a pause or a finish request are still captured
  // the strobe rise that the host makes at termination comes together
  // with stop; once stop is seen in termination no edge carries data
  // the request line stays high until T_RP+1 cycles after ready drops, and at least for the first cycle
  // of termination, and low from then until idle, so a start request is only taken back in the idle state
  // the extra counter saturates; it is a status for the core only
  // high_mode is kept for the core; capture never limits extra words,
  // so both the low and the high mode allowances are met
  // the crc flag is sticky until a new command clears it; a miscompare
  // landing in the same cycle as the clear wins only if the flag was not already set
  // the ready line is driven from the first cycle that acknowledge is
  // seen until acknowledge is seen low again at the end of the burst
  // outputs all come from the state register, busy included
  // the link clock has no fixed phase to the host clock, so nothing
  // here may assume a count of host cycles between two link events
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_REQ  = 3'b001,
    S_RUN  = 3'b010,
    S_PAUS = 3'b011,
    S_TERM = 3'b100,
    S_END  = 3'b101
  } udo_state_e;

  typedef struct packed
  {
    udo_state_e        st;        // burst sequencing state
    logic [1:0]        ack_s;     // acknowledge synchroniser
    logic [1:0]        stop_s;    // stop synchroniser
    logic [1:0]        stb_s;     // strobe synchroniser
    logic [DATA_W-1:0] d1;        // data, first stage
    logic [DATA_W-1:0] d2;        // data, second stage, aligned with stb_s[1]
    logic              stb_prev;  // strobe one cycle behind stb_s[1]
    logic              ack_prev;  // acknowledge one cycle behind ack_s[1]
    logic              got_one;   // a word has landed in this burst
    logic              dmarq;     // request line
    logic              rdy;       // ready line level
    logic              rdy_oe;    // ready line driven
    logic              bsy;       // burst in progress, registered
    logic [CNT_W-1:0]  cnt;       // timing down-counter
    logic [2:0]        extra;     // words seen since ready dropped
    logic [DATA_W-1:0] word;      // last captured word
    logic [DATA_W-1:0] crc;       // crc word latched from the host
    logic              wv;        // word strobe, one cycle
    logic              err;       // sticky crc miscompare
  } udo_dev_s;

  udo_dev_s s_reg, s_next;
  logic stb_edge;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    // synchronisers and delayed copies for edge detection
    s_next.ack_s  = {s_reg.ack_s[0], lnk.dmack};
    s_next.stop_s = {s_reg.stop_s[0], lnk.stop};
    s_next.stb_s  = {s_reg.stb_s[0], lnk.hstrobe};
    s_next.d1 = lnk.dd_out;
    s_next.d2 = s_reg.d1;
    s_next.stb_prev = s_reg.stb_s[1];
    s_next.ack_prev = s_reg.ack_s[1];
    s_next.wv = 1'b0;
    stb_edge = s_reg.stb_s[1] != s_reg.stb_prev;
    if (s_reg.cnt != '0) s_next.cnt = s_reg.cnt - 1'b1;
    // capture on either strobe edge while a burst is live
    if (stb_edge && s_reg.ack_prev && (s_reg.st == S_RUN || s_reg.st == S_PAUS
        || (s_reg.st == S_TERM && !s_reg.stop_s[1])))
    begin
      s_next.word = s_reg.d2;
      s_next.wv = 1'b1;
      s_next.got_one = 1'b1;
      if (!s_reg.rdy && s_reg.extra != 3'h7) s_next.extra = s_reg.extra + 1'b1;
    end
    if (cmd_clear) s_next.err = 1'b0;
    // ---------------------------------------------------------------
    // burst sequencing
    // ---------------------------------------------------------------
    case (s_reg.st)
      // wait for a start request while acknowledge is low
      S_IDLE:
      begin
        s_next.got_one = 1'b0;
        if (start && !s_reg.ack_s[1])
        begin
          s_next.dmarq = 1'b1;
          s_next.st = S_REQ;
        end
      end
      // drive ready low on acknowledge, raise it once stop drops
      S_REQ:
      begin
        if (s_reg.ack_s[1] && !s_reg.rdy_oe)
        begin
          s_next.rdy_oe = 1'b1;
          s_next.rdy = 1'b0;
        end
        if (s_reg.rdy_oe && !s_reg.stop_s[1])
        begin
          s_next.rdy = 1'b1;
          s_next.st = S_RUN;
        end
      end
      // words flow; pause or finish only after the first word
      S_RUN:
        if (s_reg.got_one && (pause || finish))
        begin
          s_next.rdy = 1'b0;
          s_next.extra = '0;
          s_next.cnt = T_RP;
          s_next.st = finish ? S_TERM : S_PAUS;
        end
      // ready low, host held off
      S_PAUS:
        if (finish)
        begin
          s_next.st = S_TERM;
        end
        else if (!pause)
        begin
          s_next.rdy = 1'b1;
          s_next.st = S_RUN;
        end
      // drop the request after the ready-to-request gap, take the crc
      S_TERM:
      begin
        if (s_reg.cnt == '0) s_next.dmarq = 1'b0;
        if (s_reg.ack_prev && !s_reg.ack_s[1])
        begin
          s_next.crc = s_reg.d2;
          if (s_reg.d2 != crc_own && !s_reg.err) s_next.err = 1'b1;
          s_next.rdy_oe = 1'b0;
          s_next.cnt = T_ZIORDY;
          s_next.st = S_END;
        end
      end
      // ready line released, settle before the next burst
      default:
        if (s_reg.cnt == '0) s_next.st = S_IDLE;
    endcase
    // registered busy so the output comes straight from a flop
    s_next.bsy = (s_next.st != S_IDLE);
    if (reset)
    begin
      s_next = '0;
      s_next.st = S_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // state register and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    s_reg <= s_next;
  end

  assign lnk.dmarq      = s_reg.dmarq;
  assign lnk.ddmardy    = s_reg.rdy;
  assign lnk.ddmardy_oe = s_reg.rdy_oe;
  assign word           = s_reg.word;
  assign word_valid     = s_reg.wv;
  assign extra_cnt      = s_reg.extra;
  assign busy           = s_reg.bsy;
  assign crc_err        = s_reg.err;
  assign crc_got        = s_reg.crc;
  logic unused_mode;
  assign unused_mode = high_mode & (EXTRA_LOW != EXTRA_HIGH);
endmodule

// File: verilog/udo_host.sv
// host end: drives dmack, stop, hstrobe and data words, sends crc at device termination
`timescale 1ns/1ns
module udo_host
  import udo_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  udo_if.host                    lnk,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wvalid,
  output logic                   wready,      // word taken this cycle
  input  wire logic [DATA_W-1:0] crc_val,
  output logic                   in_burst
);
  typedef enum logic [2:0]
  {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_ENV  = 3'b010,
    H_XFER = 3'b011,
    H_TERM = 3'b100,
    H_HOLD = 3'b101
  } udo_hst_e;

  typedef struct packed
  {
    udo_hst_e          st;
    logic [1:0]        rq_s, rdy_s;
    logic              ack, stop, stb, oe, first, take, inb;
    logic [DATA_W-1:0] d;
    logic [CNT_W-1:0]  cnt;
  } udo_hst_s;

  udo_hst_s h_reg, h_next;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    h_next = h_reg;
    h_next.rq_s  = {h_reg.rq_s[0], lnk.dmarq};
    h_next.rdy_s = {h_reg.rdy_s[0], lnk.ddmardy & lnk.ddmardy_oe};
    h_next.take = 1'b0;
    if (h_reg.cnt != '0) h_next.cnt = h_reg.cnt - 1'b1;
    case (h_reg.st)
      H_IDLE:
      begin
        h_next.ack = 1'b0;
        if (h_reg.rq_s[1])
        begin
          h_next.stop = 1'b1;
          h_next.stb = 1'b1;
          h_next.cnt = T_ACK;
          h_next.st = H_SETUP;
        end
      end
      H_SETUP:
        if (h_reg.cnt == '0)
        begin
          h_next.ack = 1'b1;
          h_next.cnt = T_ENV - 1'b1;
          h_next.st = H_ENV;
        end
      H_ENV:
        if (h_reg.cnt == '0)
        begin
          h_next.stop = 1'b0;
          h_next.first = 1'b1;
          h_next.st = H_XFER;
        end
      H_XFER:
        if (!h_reg.rq_s[1])
        begin
          h_next.stop = 1'b1;
          h_next.stb = 1'b1;
          h_next.d = crc_val;
          h_next.oe = 1'b1;
          h_next.cnt = T_MLI + T_DVS;
          h_next.st = H_TERM;
        end
        else if (h_reg.cnt == '0 && h_reg.rdy_s[1] && wvalid && !h_reg.oe)
        begin
          h_next.d = wdata;
          h_next.oe = 1'b1;
          h_next.take = 1'b1;
          h_next.cnt = T_DVS;
        end
        else if (h_reg.cnt == '0 && h_reg.oe)
        begin
          h_next.stb = !h_reg.stb;
          h_next.first = 1'b0;
          h_next.oe = 1'b0; // keeps data value, only marks word used
          h_next.cnt = (T_CYC > T_DVS + T_DVH) ? T_CYC - T_DVS : T_DVH;
        end
      H_TERM:
        if (h_reg.cnt == '0 && !h_reg.rdy_s[1])
        begin
          h_next.ack = 1'b0;
          h_next.cnt = T_ACK;
          h_next.st = H_HOLD;
        end
      default:
        if (h_reg.cnt == '0)
        begin
          h_next.stop = 1'b0;
          h_next.oe = 1'b0;
          h_next.st = H_IDLE;
        end
    endcase
    // registered burst flag so the output comes straight from a flop
    h_next.inb = (h_next.st != H_IDLE);
    if (reset)
    begin
      h_next = '0;
      h_next.st = H_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // state register and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    h_reg <= h_next;
  end

  assign lnk.dmack   = h_reg.ack;
  assign lnk.stop    = h_reg.stop;
  assign lnk.hstrobe = h_reg.stb;
  assign lnk.dd_out  = h_reg.d;
  assign lnk.dd_oe   = h_reg.ack;
  assign wready      = h_reg.take;
  assign in_burst    = h_reg.inb;
endmodule

// File: verification/udo_properties.sv
// checker: link-level properties of the data-out burst
`timescale 1ns/1ns
module udo_properties (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        dmarq,
  input wire logic        dmack,
  input wire logic        stop,
  input wire logic        hstrobe,
  input wire logic [15:0] dd_out,
  input wire logic        dd_oe,
  input wire logic        ddmardy,
  input wire logic        ddmardy_oe
);
  // ----------------
  // link properties
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // quiet end state, and a data edge inside a running burst
  sequence s_end; stop && hstrobe && !dmarq && !ddmardy; endsequence
  sequence s_edge; $changed(hstrobe) && dmarq && dmack && !stop; endsequence
  AST_ACK_REQ: assert property ($rose(dmack) |-> dmarq)
    else $error("ack without request");
  AST_ACK_SET: assert property ($rose(dmack) |-> $past(stop && hstrobe, 3))
    else $error("ack too early");
  AST_ACK_HOLD: assert property (dmack && dmarq |=> dmack)
    else $error("ack dropped in burst");
  AST_STOP_LO: assert property ($rose(dmack) |-> ##[1:3] !stop)
    else $error("stop not dropped");
  AST_RDY_UP: assert property ($fell(stop) && dmack |-> ##[1:12] ddmardy)
    else $error("ready late");
  AST_DVS: assert property (s_edge |-> dd_out == $past(dd_out, 2))
    else $error("data setup short");
  AST_DVH: assert property (s_edge |=> $stable(dd_out))
    else $error("data hold short");
  AST_CYC: assert property (s_edge |=> $stable(hstrobe)[*5])
    else $error("strobe edges too close");
  AST_RP: assert property ($fell(dmarq) && dmack |-> $past(!ddmardy, 10))
    else $error("request dropped early");
  AST_RFS: assert property ($fell(ddmardy) && dmack |-> ##8 $stable(hstrobe)[*6])
    else $error("strobe after ready drop");
  AST_TERM: assert property ($fell(dmarq) && dmack |-> ##[0:8] (stop && hstrobe))
    else $error("stop or strobe late");
  AST_END: assert property ($fell(dmack) |-> s_end ##1 stop[*2])
    else $error("ack dropped early");
  AST_REL: assert property ($fell(dmack) |-> ##[1:12] !ddmardy_oe)
    else $error("ready line held");
endmodule

// File: verification/udma_data_out_burst_tb.sv
// testbench: device-terminated data-out bursts between the two ends
`timescale 1ns/1ns
module udma_data_out_burst_tb
  import udo_pkg::*;
;
  logic              clk = 0, link_clk = 0, reset = 1, wvalid = 0;
  logic              start = 0, pause = 0, finish = 0, cmd_clear = 0, feed_en = 0;
  logic [DATA_W-1:0] wdata = 16'h0, crc_own = 16'h0, crc_val = 16'h0, nxt = 16'h1000;
  logic [DATA_W-1:0] word, crc_got;
  logic              word_valid, busy, crc_err, wready, in_burst;
  logic [2:0]        extra_cnt;
  logic [DATA_W-1:0] got[$], sent[$];
  int                bad_count = 0, cmp_count = 0, cyc = 0, i, base;
  // clocks, link clock out of phase
  always #5 clk = ~clk;
  initial #7 forever #15 link_clk = ~link_clk;
  udo_if lnk ();
  udo_device udo_device_i (.link_clk(link_clk), .reset(reset), .lnk(lnk), .start(start),
    .pause(pause), .finish(finish), .high_mode(1'b0), .cmd_clear(cmd_clear),
    .crc_own(crc_own), .word(word), .word_valid(word_valid), .extra_cnt(extra_cnt),
    .busy(busy), .crc_err(crc_err), .crc_got(crc_got));
  udo_host udo_host_i (.clk(clk), .reset(reset), .lnk(lnk), .wdata(wdata), .wvalid(wvalid),
    .wready(wready), .crc_val(crc_val), .in_burst(in_burst));
  udo_properties udo_properties_i (.clk(clk), .reset(reset), .dmarq(lnk.dmarq),
    .dmack(lnk.dmack), .stop(lnk.stop), .hstrobe(lnk.hstrobe), .dd_out(lnk.dd_out),
    .dd_oe(lnk.dd_oe), .ddmardy(lnk.ddmardy), .ddmardy_oe(lnk.ddmardy_oe));
  // word source: valid held, next word once one is taken
  always @(negedge clk)
  begin
    wvalid <= feed_en;
    wdata  <= nxt;
  end
  always @(posedge clk)
    if (wready)
    begin
      sent.push_back(wdata);
      nxt <= nxt + 16'h1;
    end
  // words landed at the device, and the hang limit
  always @(posedge link_clk)
    if (word_valid)
      got.push_back(word);
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      test_done();
    end
  end
  // ----------------
  // tasks
  // ----------------
  task test_done();
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wait_got(input int n);
    for (i = 0; i < 600 && got.size() < n; i++)
      @(posedge link_clk);
    chk("count", 16'(got.size() >= n), 16'h1);
  endtask
  // one burst: start pulse, optional pause, device termination
  task burst(input logic [15:0] own, input logic [15:0] hv, input int nw, input logic pz,
             input logic early);
    base = got.size();
    @(negedge link_clk);
    crc_own = own;
    start = 1;
    finish = early;
    @(negedge link_clk);
    start = 0;
    @(negedge clk);
    crc_val = hv;
    feed_en = 1;
    wait_got(base + nw);
    if (pz)
    begin
      @(negedge link_clk);
      pause = 1;
      repeat (30) @(posedge link_clk);
      i = got.size();
      repeat (20) @(posedge link_clk);
      chk("still", 16'(got.size()), 16'(i));
      chk("extra", 16'(extra_cnt <= EXTRA_LOW), 16'h1);
      @(negedge link_clk);
      pause = 0;
      wait_got(i + 2);
    end
    @(negedge link_clk);
    finish = 1;
    for (i = 0; i < 600 && (busy || in_burst); i++)
      @(posedge link_clk);
    chk("idle", {14'h0, busy, in_burst}, 16'h0);
    @(negedge clk);
    feed_en = 0;
    @(negedge link_clk);
    finish = 0;
    repeat (10) @(posedge link_clk);
    chk("seen", 16'(got.size() > base), 16'h1);
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 0;
    burst(16'h1234, 16'h1234, 4, 1, 0);
    chk("err", {15'h0, crc_err}, 16'h0);
    chk("crc", crc_got, 16'h1234);
    burst(16'h00FF, 16'h0F0F, 3, 0, 0);
    chk("err", {15'h0, crc_err}, 16'h1);
    burst(16'h0001, 16'h0002, 1, 0, 1);
    chk("crc", crc_got, 16'h0002);
    chk("err", {15'h0, crc_err}, 16'h1);
    @(negedge link_clk);
    cmd_clear = 1;
    @(negedge link_clk);
    cmd_clear = 0;
    repeat (2) @(posedge link_clk);
    chk("err", {15'h0, crc_err}, 16'h0);
    chk("size", 16'(got.size()), 16'(sent.size()));
    foreach (got[k])
      chk("word", got[k], sent[k]);
    test_done();
  end
endmodule
